// >>> src/arc_capture.sv
// Converter result capture and formatter: packs each result into the data FIFO
//
// Overview of operation
// - Each completed conversion yields one 16-bit word
// - Result in upper twelve bits, inputs lowest
// - Twelve-bit result field is two's complement
// - Sample on start fall; inputs on busy rise
// - Input capture trails sampling by converter delay
// - Bipolar codes 7FF, 000, FFF, 800
// - Unipolar same codes, offset by mid-range
// - Wide variant: whole word is result
// - Wide codes 7FFF, 0000, FFFF, 8000
// - Every finished result goes into FIFO unless it is full
// - No acquisition before trigger condition matches
`default_nettype none

module arc_capture
    import arc_pkg::*;
(
    // Clock and reset
    input  wire logic               mclk_in,
    input  wire logic               rst_in,
    // Converter side
    input  wire arc_conv_t          conv_in,
    input  wire logic [WORD_W-1:0]  adc_code_in,
    input  wire logic [SDI_W-1:0]   sync_digital_inputs_in,
    // Configuration
    input  wire logic               wide_result_in,
    input  wire logic               trig_match_in,
    input  wire logic               acq_stop_in,
    // Host transfer side
    input  wire logic               host_ready_in,
    output logic                    host_valid_out,
    output arc_word_t               host_word_out,
    // Status
    output arc_word_t               holding_word_out,
    output logic                    armed_out,
    output logic                    overrun_out,
    output logic                    lag_fault_out
);

    // ============================================================
    // Edge detection on converter handshake
    // ============================================================
    arc_conv_t          conv_q_ff;                    // Previous handshake levels
    logic               start_fall;                   // Strobe falling edge
    logic               busy_rise;                    // Conversion finished
    logic               capture_evt;                  // Capture this cycle
    logic               armed_ff;                     // Trigger has matched
    logic               pending_ff;                   // Conversion in flight

    // Previous levels, inputs are synchronous to the clock
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            conv_q_ff <= '{conv_start: 1'b1, busy_n: 1'b1};
        end else begin
            conv_q_ff <= conv_in;
        end
    end

    assign start_fall  = conv_q_ff.conv_start && !conv_in.conv_start;
    assign busy_rise   = !conv_q_ff.busy_n && conv_in.busy_n;
    assign capture_evt = busy_rise && pending_ff;

    // ============================================================
    // Trigger arming
    // ============================================================
    // trigger gate, a match wins over a stop
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            armed_ff <= 1'b0;
        end else if (trig_match_in) begin
            armed_ff <= 1'b1;
        end else if (acq_stop_in) begin
            armed_ff <= 1'b0;
        end
    end

    // analog sample starts a pending conversion when armed
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pending_ff <= 1'b0;
        end else if (start_fall && armed_ff) begin
            // New sample wins over an end in the same cycle
            pending_ff <= 1'b1;
        end else if (busy_rise) begin
            pending_ff <= 1'b0;
        end
    end

    // ============================================================
    // Lag between sample and input capture
    // ============================================================
    logic [LAG_W-1:0]   lag_ff;                       // Cycles since analog sample
    logic               lag_fault_ff;                 // Sticky early-end flag

    // count cycles from the sample edge
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lag_ff <= '0;
        end else if (start_fall) begin
            lag_ff <= '0;
        end else if (lag_ff != LAG_MAX) begin
            lag_ff <= lag_ff + LAG_W'(1);
        end
    end

    // an end sooner than the converter delay is flagged
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            lag_fault_ff <= 1'b0;
        end else if (capture_evt && (lag_ff < LAG_W'(EOC_CYC - 1))) begin
            lag_fault_ff <= 1'b1;
        end
    end

    // ============================================================
    // Word formatting
    // ============================================================
    arc_word_t          nxt_word;                     // Formatted result
    arc_word_t          holding_ff;                   // Last captured word

    // Raw code is offset binary; flipping the sign bit gives two's complement
    always_comb begin
        nxt_word = WORD_RST;
        if (wide_result_in) begin
            // wide variant, no input bits appended
            nxt_word = {~adc_code_in[WIDE_MSB], adc_code_in[WIDE_MSB-1:0]};
        end else begin
            // sign flip for the twelve-bit field
            // same code set for both ranges
            nxt_word.code = {~adc_code_in[NARROW_MSB], adc_code_in[NARROW_MSB-1:0]};
            // inputs 3..0 in the lowest bits
            nxt_word.sdi  = sync_digital_inputs_in;
        end
    end

    // latch the packed word at each completed conversion
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            holding_ff <= WORD_RST;
        end else if (capture_evt) begin
            holding_ff <= nxt_word;
        end
    end

    // ============================================================
    // Data FIFO and host output stage
    // ============================================================
    logic               fifo_ready;                   // FIFO has room
    logic               fifo_valid;                   // FIFO holds a word
    arc_word_t          fifo_word;                    // FIFO head
    logic               out_load;                     // Output stage takes head
    logic               out_valid_ff;                 // Output stage full
    arc_word_t          out_word_ff;                  // Output stage word
    logic               overrun_ff;                   // Sticky lost-word flag

    assign out_load = !out_valid_ff || host_ready_in;

    // every capture is offered in the same cycle, lost if the FIFO is full
    arc_fifo u_fifo (
        .mclk_in        (mclk_in),
        .rst_in         (rst_in),
        .push_valid_in  (capture_evt),
        .push_word_in   (nxt_word),
        .push_ready_out (fifo_ready),
        .pop_ready_in   (out_load),
        .pop_valid_out  (fifo_valid),
        .pop_word_out   (fifo_word)
    );

    // one-entry output stage, holds while the host stalls
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            out_valid_ff <= 1'b0;
            out_word_ff  <= WORD_RST;
        end else if (out_load) begin
            out_valid_ff <= fifo_valid;
            out_word_ff  <= fifo_word;
        end
    end

    // A capture into a full FIFO cannot be held; report it
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            overrun_ff <= 1'b0;
        end else if (capture_evt && !fifo_ready) begin
            overrun_ff <= 1'b1;
        end
    end

    // Outputs straight from flip-flops
    assign host_valid_out   = out_valid_ff;
    assign host_word_out    = out_word_ff;
    assign holding_word_out = holding_ff;
    assign armed_out        = armed_ff;
    assign overrun_out      = overrun_ff;
    assign lag_fault_out    = lag_fault_ff;

    // ============================================================
    // Checks
    // ============================================================
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    // digital inputs land in the low bits
    input_bits_a: assert property ((capture_evt && !wide_result_in)
        |=> holding_ff.sdi == $past(sync_digital_inputs_in))
        else $error("Digital inputs not in low bits");

    // narrow field is the sign-flipped code
    narrow_code_a: assert property ((capture_evt && !wide_result_in)
        |=> holding_ff.code == {~$past(adc_code_in[11]), $past(adc_code_in[10:0])})
        else $error("Narrow field not two's complement");

    mid_zero_a: assert property ((capture_evt && !wide_result_in
        && adc_code_in[11:0] == 12'h0800) |=> holding_ff.code == 12'h000)
        else $error("Midscale did not read zero");

    // wide word is the sign-flipped code
    wide_code_a: assert property ((capture_evt && wide_result_in)
        |=> holding_ff == {~$past(adc_code_in[15]), $past(adc_code_in[14:0])})
        else $error("Wide word not two's complement");

    trig_gate_a: assert property ($rose(pending_ff) |-> $past(armed_ff))
        else $error("Conversion accepted before trigger");

    // pending clears after a capture unless a new sample starts
    cap_after_a: assert property (capture_evt |=> !pending_ff || $past(start_fall))
        else $error("Pending not cleared at conversion end");

    // early end raises the fault flag
    early_end_a: assert property ((capture_evt && lag_ff < LAG_W'(EOC_CYC - 1))
        |=> lag_fault_out)
        else $error("Early conversion end not flagged");

    // a capture is stored or reported
    stored_a: assert property (capture_evt |=> ##1 (fifo_valid || out_valid_ff
        || overrun_out))
        else $error("Captured word vanished");

    hold_word_a: assert property ((host_valid_out && !host_ready_in)
        |=> host_valid_out && $stable(host_word_out))
        else $error("Output changed under stall");

    narrow_cap_c: cover property (capture_evt && !wide_result_in);
    wide_cap_c:   cover property (capture_evt && wide_result_in);
    stall_c:      cover property ((host_valid_out && !host_ready_in) [*3]);
    overrun_c:    cover property ($rose(overrun_out));

endmodule : arc_capture

`default_nettype wire

// >>> src/arc_pkg.sv
// Shared constants and types for the converter result capture block
`default_nettype none

package arc_pkg;

    // ============================================================
    // Timing
    // ============================================================
    localparam int CLK_PERIOD_NS = 100;               // Master clock period
    localparam int EOC_DELAY_NS  = 280;               // Converter end-of-conversion lag
    // Least lag in whole cycles, rounded up
    localparam int EOC_CYC       = (EOC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LAG_W         = 4;                 // Width of the lag counter

    // ============================================================
    // Word layout
    // ============================================================
    localparam int WORD_W        = 16;                // Packed word width
    localparam int CODE_W        = 12;                // Narrow conversion field width
    localparam int SDI_W         = 4;                 // Synchronous digital input count
    localparam int NARROW_MSB    = 11;                // Sign bit of a narrow raw code
    localparam int WIDE_MSB      = 15;                // Sign bit of a wide raw code

    // ============================================================
    // Storage
    // ============================================================
    localparam int FIFO_DEPTH    = 16;                // Data FIFO entries
    localparam int FIFO_AW       = 4;                 // FIFO index width

    // ============================================================
    // Reset values
    // ============================================================
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [LAG_W-1:0]  LAG_MAX  = 4'hF;    // Lag counter saturation

    // Packed result word: code on top, digital inputs at the bottom
    typedef struct packed {
        logic [CODE_W-1:0] code;                      // Two's complement result
        logic [SDI_W-1:0]  sdi;                       // Inputs 3..0
    } arc_word_t;

    // Converter-side handshake signals
    typedef struct packed {
        logic conv_start;                             // Conversion strobe, sample on fall
        logic busy_n;                                 // Busy, low while converting
    } arc_conv_t;

endpackage : arc_pkg

`default_nettype wire

// >>> src/arc_fifo.sv
// Data FIFO held in flip-flops, in-order, with valid/ready on both sides
`default_nettype none

module arc_fifo
    import arc_pkg::*;
(
    // Clock and reset
    input  wire logic      mclk_in,
    input  wire logic      rst_in,
    // Fill side
    input  wire logic      push_valid_in,
    input  wire arc_word_t push_word_in,
    output logic           push_ready_out,
    // Drain side
    input  wire logic      pop_ready_in,
    output logic           pop_valid_out,
    output arc_word_t      pop_word_out
);

    // ============================================================
    // Storage and pointers
    // ============================================================
    arc_word_t             mem_ff [FIFO_DEPTH];       // Entry storage
    logic [FIFO_AW-1:0]    wr_ptr_ff;                 // Next write index
    logic [FIFO_AW-1:0]    rd_ptr_ff;                 // Next read index
    logic [FIFO_AW:0]      count_ff;                  // Occupied entries
    logic                  push;                      // Write accepted
    logic                  pop;                       // Read accepted

    // Full and empty come straight from the occupancy count
    assign push_ready_out = (count_ff != (FIFO_AW+1)'(FIFO_DEPTH));
    assign pop_valid_out  = (count_ff != '0);
    assign pop_word_out   = mem_ff[rd_ptr_ff];
    assign push           = push_valid_in && push_ready_out;
    assign pop            = pop_ready_in && pop_valid_out;

    // Entry write, no reset needed on data
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= push_word_in;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            // Pointers wrap naturally at the power-of-two depth
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + FIFO_AW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + FIFO_AW'(1);
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            count_ff <= '0;
        end else if (push && !pop) begin
            count_ff <= count_ff + (FIFO_AW+1)'(1);
        end else if (pop && !push) begin
            count_ff <= count_ff - (FIFO_AW+1)'(1);
        end
    end

    // ============================================================
    // Checks
    // ============================================================
    // occupancy bookkeeping
    fifo_count_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (push && !pop) |=> count_ff == $past(count_ff) + (FIFO_AW+1)'(1))
        else $error("FIFO count did not grow on a lone push");

endmodule : arc_fifo

`default_nettype wire

// >>> verif/arc_conv_model.sv
// Behavioural converter: start strobe, busy line, result code and digital inputs
`default_nettype none

module arc_conv_model
    import arc_pkg::*;
(
    // Clock
    input  wire logic              mclk_in,
    // Bench command
    input  wire logic              go_in,
    input  wire logic [LAG_W-1:0]  lag_in,
    input  wire logic [WORD_W-1:0] code_in,
    input  wire logic [SDI_W-1:0]  sdi_in,
    // Converter pins
    output arc_conv_t              conv_out,
    output logic [WORD_W-1:0]      adc_code_out,
    output logic [SDI_W-1:0]       sdi_out,
    output logic                   done_out
);
    timeunit 1ns;
    timeprecision 1ns;

    // ============================================================
    // Conversion sequencer
    // ============================================================
    // One conversion per go request; lines carry wrong values outside the valid cycle
    initial begin
        conv_out     = '{conv_start: 1'b1, busy_n: 1'b1};
        adc_code_out = 16'h0000;
        sdi_out      = 4'h0;
        done_out     = 1'b0;
        forever begin
            @(posedge mclk_in);
            if (go_in) begin
                @(negedge mclk_in);
                adc_code_out        = ~code_in;
                sdi_out             = ~sdi_in;
                conv_out.conv_start = 1'b0;
                @(negedge mclk_in);
                conv_out.conv_start = 1'b1;
                conv_out.busy_n     = 1'b0;
                // Busy rises lag_in cycles after the strobe fall
                repeat (int'(lag_in) - 1) @(negedge mclk_in);
                conv_out.busy_n = 1'b1;
                adc_code_out    = code_in;
                sdi_out         = sdi_in;
                done_out        = 1'b1;
                @(negedge mclk_in);
                // Hold time over, so the lines show the inverse
                adc_code_out = ~code_in;
                sdi_out      = ~sdi_in;
                done_out     = 1'b0;
                while (go_in) @(posedge mclk_in);
            end
        end
    end

endmodule : arc_conv_model

`default_nettype wire

// >>> verif/test_adc_result_capture_formatter.sv
// Self-checking testbench for the converter result capture block
`default_nettype none

module test_adc_result_capture_formatter;
    import arc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ============================================================
    // Signals
    // ============================================================
    logic             mclk_in, rst_in, go, wide, trig, stop, host_ready;
    logic [LAG_W-1:0] lag;                 // Strobe fall to busy rise, cycles
    logic [15:0]      code, adc_code;      // Raw code requested and on the pins
    logic [3:0]       sdi, sdi_pins;       // Digital inputs requested and on the pins
    arc_conv_t        conv;                // Converter handshake lines
    logic             done, host_valid, armed, overrun, lag_fault;
    arc_word_t        host_word, holding;  // Design word outputs
    int               n_errors = 0;        // Mismatches
    int               num_checks = 0;      // Comparisons

    // ============================================================
    // Instances
    // ============================================================
    arc_capture uut (.mclk_in(mclk_in), .rst_in(rst_in), .conv_in(conv),
        .adc_code_in(adc_code), .sync_digital_inputs_in(sdi_pins),
        .wide_result_in(wide), .trig_match_in(trig), .acq_stop_in(stop),
        .host_ready_in(host_ready), .host_valid_out(host_valid),
        .host_word_out(host_word), .holding_word_out(holding), .armed_out(armed),
        .overrun_out(overrun), .lag_fault_out(lag_fault));
    arc_conv_model adc (.mclk_in(mclk_in), .go_in(go), .lag_in(lag), .code_in(code),
        .sdi_in(sdi), .conv_out(conv), .adc_code_out(adc_code), .sdi_out(sdi_pins),
        .done_out(done));

    // Clock generator, 100 ns period
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end

    // ============================================================
    // Shared tasks
    // ============================================================
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One conversion through the model; waits bounded for its end
    task automatic convert(input logic [15:0] raw, input logic [3:0] s, input int l);
        int k;
        @(negedge mclk_in);
        code = raw;
        sdi  = s;
        lag  = LAG_W'(l);
        go   = 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge mclk_in);
            if (done === 1'b1) break;
        end
        if (k == 20) begin
            n_errors++;
            stop_test();
        end
        @(negedge mclk_in);
        go = 1'b0;
        repeat (3) @(negedge mclk_in);
    endtask : convert

    // Waits bounded for a host word, compares it, then takes it
    task automatic pop_expect(input logic [15:0] exp);
        int k;
        for (k = 0; k < 30; k++) begin
            @(negedge mclk_in);
            if (host_valid === 1'b1) break;
        end
        if (k == 30) begin
            n_errors++;
            stop_test();
        end
        chk(host_word, exp);
        host_ready = 1'b1;
        @(negedge mclk_in);
        host_ready = 1'b0;
    endtask : pop_expect

    // Pulses the arming inputs and checks the armed level
    task automatic arm(input logic t, input logic p, input logic exp);
        @(negedge mclk_in);
        trig = t;
        stop = p;
        @(negedge mclk_in);
        trig = 1'b0;
        stop = 1'b0;
        @(negedge mclk_in);
        chk(16'(armed), 16'(exp));
    endtask : arm

    // ============================================================
    // Scenarios
    // ============================================================
    task automatic test_idle();
        chk(holding, 16'h0000);
        chk({12'h000, host_valid, armed, overrun, lag_fault}, 16'h0000);
        convert(16'h0123, 4'h5, 4);
        chk(16'(host_valid), 16'h0000);
        arm(1'b1, 1'b0, 1'b1);
        arm(1'b0, 1'b1, 1'b0);
        convert(16'h0456, 4'h6, 4);
        chk(16'(host_valid), 16'h0000);
        arm(1'b1, 1'b1, 1'b1);
    endtask : test_idle

    // Narrow codes queue up unread, then drain in order
    task automatic test_narrow();
        logic [15:0] raw [5] = '{16'hA000, 16'h5800, 16'h3FFF, 16'hC7FF, 16'h0801};
        logic [11:0] exp [5] = '{12'h800, 12'h000, 12'h7FF, 12'hFFF, 12'h001};
        wide = 1'b0;
        for (int i = 0; i < 5; i++) begin
            convert(raw[i], 4'(3 + 5 * i), 4);
            chk(holding, {exp[i], 4'(3 + 5 * i)});
        end
        for (int i = 0; i < 5; i++) pop_expect({exp[i], 4'(3 + 5 * i)});
        @(negedge mclk_in);
        chk(16'(host_valid), 16'h0000);
    endtask : test_narrow

    // Wide codes: whole word is the result, inputs not appended
    task automatic test_wide();
        logic [15:0] raw [4] = '{16'h0000, 16'h8000, 16'hFFFF, 16'h7FFF};
        logic [15:0] exp [4] = '{16'h8000, 16'h0000, 16'h7FFF, 16'hFFFF};
        wide = 1'b1;
        for (int i = 0; i < 4; i++) begin
            convert(raw[i], 4'hA, 4);
            chk(holding, exp[i]);
            pop_expect(exp[i]);
        end
        wide = 1'b0;
    endtask : test_wide

    // Fill FIFO plus output stage, one more overruns; kept words stay in order
    task automatic test_overrun();
        for (int i = 0; i < FIFO_DEPTH + 2; i++) begin
            convert(16'h0100 + 16'(i), 4'(i), 4);
            if (i == FIFO_DEPTH) chk(16'(overrun), 16'h0000);
        end
        chk(16'(overrun), 16'h0001);
        for (int i = 0; i < FIFO_DEPTH + 1; i++) begin
            pop_expect({12'h900 + 12'(i), 4'(i)});
        end
        @(negedge mclk_in);
        chk(16'(host_valid), 16'h0000);
    endtask : test_overrun

    // Least legal lag is clean, one cycle less flags a fault
    task automatic test_lag();
        convert(16'h0F0F, 4'h9, 3);
        chk(16'(lag_fault), 16'h0000);
        pop_expect({12'h70F, 4'h9});
        convert(16'h0F0F, 4'h9, 2);
        chk(16'(lag_fault), 16'h0001);
    endtask : test_lag

    // Mid-run reset clears sticky flags, arming and the queued word
    task automatic test_reset();
        @(negedge mclk_in);
        rst_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        rst_in = 1'b0;
        @(negedge mclk_in);
        chk({12'h000, host_valid, armed, overrun, lag_fault}, 16'h0000);
        chk(holding, 16'h0000);
    endtask : test_reset

    // ============================================================
    // Main sequence
    // ============================================================
    initial begin
        {rst_in, go, wide, trig, stop, host_ready} = 6'b100000;
        lag  = 4'h4;
        code = 16'h0000;
        sdi  = 4'h0;
        repeat (6) @(negedge mclk_in);
        rst_in = 1'b0;
        repeat (2) @(negedge mclk_in);
        test_idle();
        test_narrow();
        test_wide();
        test_overrun();
        test_lag();
        test_reset();
        stop_test();
    end

endmodule : test_adc_result_capture_formatter

`default_nettype wire
